// ### dv/dma_event_model.sv
// Purpose: Stand-in for the DMA engines and side units that pulse events
// Assumes: Tasks are entered just after a rising edge
// Notes: Each burst ends with an idle cycle, so no signal is driven twice in a step
`default_nettype none

module dma_event_model (
  // Clock
  input wire logic core_clk,
  // Events toward the block
  output var qptr_pkg::rx_events_t rx_ev,
  output var qptr_pkg::tx_events_t tx_ev,
  output var qptr_pkg::misc_events_t misc_ev
);
  timeunit 1ns;
  timeprecision 1ns;
  logic act;
  initial begin
    act = 1'b0;
    rx_ev = '0;
    tx_ev = '0;
    misc_ev = '0;
  end
  // Packed as {rx, tx without active, misc}; held n cycles so n pulses land
  task automatic drive(input logic [16:0] e, input int n);
    rx_ev <= e[16:11];
    tx_ev <= {e[10:4], act};
    misc_ev <= e[3:0];
    repeat (n) @(posedge core_clk);
    rx_ev <= '0;
    tx_ev <= {7'h00, act};
    misc_ev <= '0;
    @(posedge core_clk);
  endtask : drive
  task automatic set_active(input logic a);
    act = a;
    tx_ev <= {7'h00, a};
    @(posedge core_clk);
  endtask : set_active
endmodule : dma_event_model

`default_nettype wire

// ### dv/mac_queue_status_props.sv
// Purpose: Checker for the queue pointer and status block
// Assumes: Sees the top module ports only
// Notes: Bound to the design at the foot of this file
`default_nettype none

module mac_queue_status_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Events and pointers
  input wire qptr_pkg::rx_events_t rx_ev,
  input wire qptr_pkg::tx_events_t tx_ev,
  input wire qptr_pkg::misc_events_t misc_ev,
  input wire logic [31:0] rx_desc_addr,
  input wire logic [31:0] tx_desc_addr,
  input wire logic rx_retry_fetch,
  input wire logic rx_reclaim_buffer
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic rx_wr;
  logic tx_wr;
  logic rx_move;
  logic tx_move;
  assign rx_wr = psel && penable && pwrite && paddr == qptr_pkg::RX_QUEUE_POINTER_OFS;
  assign tx_wr = psel && penable && pwrite && paddr == qptr_pkg::TX_QUEUE_POINTER_OFS;
  assign rx_move = rx_ev.buffer_used || rx_ev.buffer_wrap;
  assign tx_move = tx_ev.buffer_used || tx_ev.buffer_wrap;
  // A pointer write with no DMA progress in the same cycle
  sequence s_rx_load; rx_wr && !rx_move; endsequence
  sequence s_tx_load; tx_wr && !tx_move; endsequence

  a_rx_load_base: assert property (
    s_rx_load |=> rx_desc_addr == ($past(pwdata) & qptr_pkg::PTR_MASK))
    else $error("rx pointer did not load written base");
  a_rx_idle_hold: assert property (
    !rx_wr && !rx_move |=> $stable(rx_desc_addr))
    else $error("rx pointer moved without cause");
  a_rx_step_eight: assert property (
    rx_ev.buffer_used && !rx_ev.buffer_wrap && !rx_ev.overrun && !rx_wr |=>
      rx_desc_addr == $past(rx_desc_addr) + 32'h0000_0008 ||
      rx_desc_addr < $past(rx_desc_addr))
    else $error("rx pointer step wrong");
  a_tx_write_locked: assert property (
    s_tx_load ##0 tx_ev.active |=> $stable(tx_desc_addr))
    else $error("tx pointer written while active");
  a_tx_write_loads: assert property (
    s_tx_load ##0 !tx_ev.active |=> tx_desc_addr == ($past(pwdata) & qptr_pkg::PTR_MASK))
    else $error("tx pointer did not load while idle");
  a_overrun_no_step: assert property (
    rx_ev.buffer_used && rx_ev.overrun && !rx_ev.buffer_wrap && !rx_wr |=>
      $stable(rx_desc_addr))
    else $error("rx pointer advanced on overrun");
  a_reclaim_follows: assert property (
    rx_ev.overrun |=> rx_reclaim_buffer)
    else $error("reclaim missing after overrun");
  a_reclaim_cause: assert property (
    rx_reclaim_buffer |-> $past(rx_ev.overrun))
    else $error("reclaim without overrun");
  a_retry_cause: assert property (
    rx_retry_fetch |-> $past(rx_ev.frame_start))
    else $error("retry without frame start");
endmodule : mac_queue_status_chk

bind mac_queue_status mac_queue_status_chk u_mac_queue_status_chk (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_ev(rx_ev), .tx_ev(tx_ev), .misc_ev(misc_ev), .rx_desc_addr(rx_desc_addr),
  .tx_desc_addr(tx_desc_addr), .rx_retry_fetch(rx_retry_fetch),
  .rx_reclaim_buffer(rx_reclaim_buffer)
);

`default_nettype wire

// ### dv/mac_queue_status_tb_top.sv
// Purpose: Directed bench for the queue pointer and status block
// Assumes: Zero-wait APB slave, event pulses from the model
// Notes: Tests run in order; status left by one test is cleared before a later test checks it, except the underrun bit from the tx wrap test
`default_nettype none

module mac_queue_status_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_RX = qptr_pkg::RX_QUEUE_POINTER_OFS;
  localparam logic [7:0] A_TX = qptr_pkg::TX_QUEUE_POINTER_OFS;
  localparam logic [7:0] A_RS = qptr_pkg::RECEIVE_STATUS_OFS;
  localparam logic [7:0] A_IS = qptr_pkg::INTERRUPT_STATUS_OFS;
  localparam logic [7:0] A_TS = qptr_pkg::TRANSMIT_STATUS_OFS;
  logic core_clk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  qptr_pkg::rx_events_t rx_ev;
  qptr_pkg::tx_events_t tx_ev;
  qptr_pkg::misc_events_t misc_ev;
  logic [31:0] rx_desc_addr;
  logic [31:0] tx_desc_addr;
  logic rx_retry_fetch;
  logic rx_reclaim_buffer;
  logic [31:0] rd;
  logic err_seen;
  int mismatches = 0;
  int checks_done = 0;
  int evp[12] = '{3, 16, 13, 7, 6, 5, 4, 8, 12, 0, 2, 1};
  int bitp[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 11, 12, 13};

  mac_queue_status u_mac_queue_status (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_ev(rx_ev), .tx_ev(tx_ev), .misc_ev(misc_ev), .rx_desc_addr(rx_desc_addr),
    .tx_desc_addr(tx_desc_addr), .rx_retry_fetch(rx_retry_fetch),
    .rx_reclaim_buffer(rx_reclaim_buffer)
  );
  dma_event_model u_dma_event_model (
    .core_clk(core_clk), .rx_ev(rx_ev), .tx_ev(tx_ev), .misc_ev(misc_ev)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One APB transfer, then an idle cycle so psel is never assigned twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    err_seen = pslverr;
    if (pready !== 1'b1) mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
    check(32'(err_seen), 32'(!(a inside {A_RX, A_TX, A_RS, A_IS, A_TS})));
  endtask : rchk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    foreach (bitp[k]) begin
      if (k < 6) rchk(k == 5 ? 8'h00 : A_TS + 8'(4 * k), 32'h0000_0000);
    end
    $display("test reset values done");
    apb(1'b1, A_RX, 32'h0000_2003);
    rchk(A_RX, 32'h0000_2000);
    u_dma_event_model.drive(17'h0_8000, 3);
    rchk(A_RX, 32'h0000_2018);
    u_dma_event_model.drive(17'h0_C000, 1);
    rchk(A_RX, 32'h0000_2000);
    $display("test rx pointer done");
    apb(1'b1, A_TX, 32'h0000_4000);
    u_dma_event_model.drive(17'h0_0400, 1023);
    check(tx_desc_addr, 32'h0000_5FF8);
    u_dma_event_model.drive(17'h0_0400, 1);
    check(tx_desc_addr, 32'h0000_4000);
    $display("test tx wrap done");
    u_dma_event_model.set_active(1'b1);
    apb(1'b1, A_TX, 32'h0000_8000);
    rchk(A_TS, 32'h0000_0008);
    rchk(A_TX, 32'h0000_4000);
    u_dma_event_model.drive(17'h0_0400, 2);
    check(tx_desc_addr, 32'h0000_4010);
    rchk(A_TX, 32'h0000_4000);
    u_dma_event_model.set_active(1'b0);
    apb(1'b1, A_TX, 32'h0000_8000);
    rchk(A_TX, 32'h0000_8000);
    rchk(A_IS, 32'h0000_0010);
    rchk(A_IS, 32'h0000_0000);
    u_dma_event_model.drive(17'h0_0400, 1);
    u_dma_event_model.drive(17'h0_0100, 1);
    rchk(A_TX, 32'h0000_8008);
    $display("test tx lock done");
    u_dma_event_model.drive(17'h1_3000, 1);
    rchk(A_RS, 32'h0000_0007);
    apb(1'b1, A_RS, 32'h0000_0002);
    rchk(A_RS, 32'h0000_0005);
    apb(1'b1, A_RS, 32'h0000_0000);
    rchk(A_RS, 32'h0000_0005);
    apb(1'b1, A_RS, 32'h0000_0007);
    rchk(A_RS, 32'h0000_0000);
    u_dma_event_model.drive(17'h0_2000, 1);
    rchk(A_RS, 32'h0000_0001);
    fork
      apb(1'b1, A_RS, 32'h0000_0007);
      begin
        @(posedge core_clk);
        u_dma_event_model.drive(17'h1_0000, 1);
      end
    join
    rchk(A_RS, 32'h0000_0002);
    apb(1'b1, A_RS, 32'h0000_0007);
    apb(1'b0, A_IS, 32'h0000_0000);
    $display("test receive status done");
    for (int k = 0; k < 12; k++) begin
      u_dma_event_model.drive(17'h0_0001 << evp[k], 1);
      rchk(A_IS, 32'h0000_0001 << bitp[k]);
      rchk(A_IS, 32'h0000_0000);
    end
    fork
      apb(1'b0, A_IS, 32'h0000_0000);
      begin
        @(posedge core_clk);
        u_dma_event_model.drive(17'h0_0008, 1);
      end
    join
    check(rd, 32'h0000_0000);
    rchk(A_IS, 32'h0000_0001);
    $display("test interrupt status done");
    apb(1'b1, A_RS, 32'h0000_0007);
    apb(1'b0, A_IS, 32'h0000_0000);
    u_dma_event_model.drive(17'h0_2000, 1);
    fork
      u_dma_event_model.drive(17'h0_0800, 1);
      begin
        @(posedge core_clk);
        @(negedge core_clk);
        check(32'(rx_retry_fetch), 32'h0000_0001);
      end
    join
    fork
      u_dma_event_model.drive(17'h0_9000, 1);
      begin
        @(posedge core_clk);
        @(negedge core_clk);
        check(32'(rx_reclaim_buffer), 32'h0000_0001);
      end
    join
    rchk(A_RS, 32'h0000_0005);
    rchk(A_IS, 32'h0000_0404);
    rchk(A_RX, 32'h0000_2000);
    $display("test retry and overrun done");
    report_and_stop();
  end
endmodule : mac_queue_status_tb_top

`default_nettype wire

// ### verilog/mac_queue_status.sv
// Purpose: Descriptor queue pointers and receive/interrupt status for a MAC
// Assumes: APB slave on core_clk; DMA and side units pulse events here
// Notes: Zero-wait APB; set always wins over a clear in the same cycle
//
// How it works
// [RULE1] Receive pointer loads base, reads current descriptor
// [RULE2] Transmit index advances, wraps at 1024 or wrap
// [RULE3] Transmit pointer writable only while transmit idle
// [RULE4] Software keeps pointer bit 2 zero
// [RULE5] Transmit read gives first buffer of frame
// [RULE6] Receive status bits clear on written one
// [RULE7] No-buffer flag sets on every failed attempt
// [RULE8] Receive DMA retries descriptor at each frame
// [RULE9] Frame-received flag sets when frame stored
// [RULE10] Overrun flag sets and buffer is reclaimed
// [RULE11] Interrupt status layout, cleared when read
// [RULE12] Management done sets its interrupt bit
// [RULE13] Receive complete sets on stored frame
// [RULE14] Receive used bit read sets interrupt
// [RULE15] Transmit used bit read sets interrupt
// [RULE16] Underrun on late data, error, used, rewrite
// [RULE17] Buffers exhausted mid frame sets error bit
// [RULE18] Transmit complete sets on each frame
// [RULE19] Receive overrun bit follows overrun flag set
// [RULE20] Bus error response sets its bit
// [RULE21] Valid pause frame sets its bit
// [RULE22] Pause counter reaching zero sets bit
// [RULE23] Transmit status bit 3 shows active
// [RULE24] Hardware set beats same-cycle clear
//
// Our own choices: the register offsets and the APB slave port.
`default_nettype none

module mac_queue_status (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive DMA events
  input wire qptr_pkg::rx_events_t rx_ev,
  // Transmit DMA events
  input wire qptr_pkg::tx_events_t tx_ev,
  // Management, pause and bus events
  input wire qptr_pkg::misc_events_t misc_ev,
  // Pointers to the DMA engines
  output logic [31:0] rx_desc_addr,
  output logic [31:0] tx_desc_addr,
  output logic rx_retry_fetch,
  output logic rx_reclaim_buffer
);

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic sel_rx_ptr;
  logic sel_tx_ptr;
  logic sel_rx_status;
  logic sel_irq_status;
  logic sel_tx_status;

  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  // One decode per register, shared by the write, clear and read paths
  assign sel_rx_ptr = hit(paddr, qptr_pkg::RX_QUEUE_POINTER_OFS);
  assign sel_tx_ptr = hit(paddr, qptr_pkg::TX_QUEUE_POINTER_OFS);
  assign sel_rx_status = hit(paddr, qptr_pkg::RECEIVE_STATUS_OFS);
  assign sel_irq_status = hit(paddr, qptr_pkg::INTERRUPT_STATUS_OFS);
  assign sel_tx_status = hit(paddr, qptr_pkg::TRANSMIT_STATUS_OFS);
  assign mapped = sel_rx_ptr | sel_tx_ptr | sel_rx_status | sel_irq_status | sel_tx_status;

  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // ---------------------------------------------------------------------------
  // Transmit active level and queue pointer writes
  // ---------------------------------------------------------------------------
  logic transmit_active_flag;
  logic rx_ptr_load;
  logic tx_ptr_load;
  logic tx_ptr_write_seen;

  assign transmit_active_flag = tx_ev.active; // RULE23
  assign rx_ptr_load = wr & sel_rx_ptr; // RULE1
  assign tx_ptr_write_seen = wr & sel_tx_ptr;
  // Writes during an active transmit are dropped so the DMA never jumps
  assign tx_ptr_load = tx_ptr_write_seen & ~transmit_active_flag; // RULE3

  // ---------------------------------------------------------------------------
  // Receive and transmit queue pointers
  // ---------------------------------------------------------------------------
  logic [31:0] rx_current;
  logic [31:0] tx_current;
  logic rx_advance;

  // A reclaimed buffer is not consumed, so the receive pointer stays put
  assign rx_advance = rx_ev.buffer_used & ~rx_ev.overrun; // RULE10

  queue_pointer rx_qp (
    .core_clk(core_clk),
    .rst(rst),
    .load(rx_ptr_load),
    .load_value(pwdata),
    .advance(rx_advance),
    .wrap(rx_ev.buffer_wrap),
    .base(),
    .current(rx_current)
  );

  queue_pointer tx_qp (
    .core_clk(core_clk),
    .rst(rst),
    .load(tx_ptr_load),
    .load_value(pwdata),
    .advance(tx_ev.buffer_used), // RULE2
    .wrap(tx_ev.buffer_wrap),
    .base(),
    .current(tx_current)
  );

  assign rx_desc_addr = rx_current;
  assign tx_desc_addr = tx_current;

  // ---------------------------------------------------------------------------
  // First buffer of the current transmit frame
  // ---------------------------------------------------------------------------
  logic [31:0] tx_frame_start_reg;
  logic [31:0] tx_frame_start_next;
  logic tx_in_frame_reg;
  logic tx_in_frame_next;

  always_comb begin
    tx_frame_start_next = tx_frame_start_reg;
    tx_in_frame_next = tx_in_frame_reg;
    if (tx_ptr_load) begin
      tx_frame_start_next = pwdata & qptr_pkg::PTR_MASK;
      tx_in_frame_next = 1'b0;
    end else if (tx_ev.frame_done || tx_ev.exhausted || tx_ev.underrun) begin
      // Next frame starts at the descriptor after the last one used
      tx_in_frame_next = 1'b0;
    end else if (tx_ev.buffer_used) begin
      tx_in_frame_next = 1'b1;
    end
    if (!tx_in_frame_reg && !tx_ptr_load && !tx_ev.buffer_used) begin
      tx_frame_start_next = tx_current; // RULE5
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_frame_start_reg <= qptr_pkg::PTR_RESET;
      tx_in_frame_reg <= 1'b0;
    end else begin
      tx_frame_start_reg <= tx_frame_start_next;
      tx_in_frame_reg <= tx_in_frame_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Receive retry after a failed fetch
  // ---------------------------------------------------------------------------
  logic rx_wait_buffer_reg;
  logic rx_wait_buffer_next;
  logic rx_retry_reg;
  logic rx_retry_next;
  logic rx_reclaim_reg;
  logic rx_reclaim_next;

  always_comb begin
    rx_wait_buffer_next = rx_wait_buffer_reg;
    rx_retry_next = 1'b0;
    rx_reclaim_next = rx_ev.overrun; // RULE10
    if (rx_ev.desc_owned_by_cpu) begin
      rx_wait_buffer_next = 1'b1;
    end else if (rx_ev.buffer_used) begin
      rx_wait_buffer_next = 1'b0;
    end
    // Reread the same descriptor at each new frame until one is free
    if (rx_wait_buffer_reg && rx_ev.frame_start) begin
      rx_retry_next = 1'b1; // RULE8
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_wait_buffer_reg <= 1'b0;
      rx_retry_reg <= 1'b0;
      rx_reclaim_reg <= 1'b0;
    end else begin
      rx_wait_buffer_reg <= rx_wait_buffer_next;
      rx_retry_reg <= rx_retry_next;
      rx_reclaim_reg <= rx_reclaim_next;
    end
  end

  assign rx_retry_fetch = rx_retry_reg;
  assign rx_reclaim_buffer = rx_reclaim_reg;

  // ---------------------------------------------------------------------------
  // Receive status, write one to clear
  // ---------------------------------------------------------------------------
  logic [2:0] rx_status_reg;
  logic [2:0] rx_status_next;
  logic [2:0] rx_status_set;
  logic [2:0] rx_status_clr;
  logic rx_overrun_rise;

  always_comb begin
    rx_status_set = '0;
    rx_status_set[qptr_pkg::RS_NO_BUFFER] = rx_ev.desc_owned_by_cpu; // RULE7
    rx_status_set[qptr_pkg::RS_FRAME_RECEIVED] = rx_ev.frame_stored; // RULE9
    rx_status_set[qptr_pkg::RS_OVERRUN] = rx_ev.overrun; // RULE10
    rx_status_clr = '0;
    if (wr && sel_rx_status) begin
      rx_status_clr = pwdata[qptr_pkg::RS_WIDTH-1:0]; // RULE6
    end
    // Writes only clear; a set in the same cycle survives
    rx_status_next = (rx_status_reg & ~rx_status_clr) | rx_status_set; // RULE24
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_status_reg <= '0;
    end else begin
      rx_status_reg <= rx_status_next;
    end
  end

  // Overrun interrupt tracks each new setting of the overrun flag
  assign rx_overrun_rise = rx_status_set[qptr_pkg::RS_OVERRUN]
                         & ~rx_status_reg[qptr_pkg::RS_OVERRUN]; // RULE19

  // ---------------------------------------------------------------------------
  // Interrupt status, clear on read
  // ---------------------------------------------------------------------------
  logic [13:0] irq_status_reg;
  logic [13:0] irq_status_next;
  logic [13:0] irq_set;
  logic irq_read;

  assign irq_read = rd & sel_irq_status;

  always_comb begin
    irq_set = '0;
    irq_set[qptr_pkg::IS_MGMT_DONE] = misc_ev.mgmt_done; // RULE12
    irq_set[qptr_pkg::IS_RX_COMPLETE] = rx_ev.frame_stored; // RULE13
    irq_set[qptr_pkg::IS_RX_USED] = rx_ev.desc_owned_by_cpu; // RULE14
    irq_set[qptr_pkg::IS_TX_USED] = tx_ev.used_bit_read; // RULE15
    // Software moving the pointer while transmit is idle also counts as underrun
    irq_set[qptr_pkg::IS_TX_UNDERRUN] = tx_ev.underrun | tx_ptr_load; // RULE16
    irq_set[qptr_pkg::IS_RETRY_LIMIT] = tx_ev.retry_limit; // RULE11
    irq_set[qptr_pkg::IS_TX_EXHAUSTED] = tx_ev.exhausted; // RULE17
    irq_set[qptr_pkg::IS_TX_COMPLETE] = tx_ev.frame_done; // RULE18
    irq_set[qptr_pkg::IS_RX_OVERRUN] = rx_overrun_rise; // RULE19
    irq_set[qptr_pkg::IS_BUS_ERROR] = misc_ev.bus_error; // RULE20
    irq_set[qptr_pkg::IS_PAUSE_RECEIVED] = misc_ev.pause_received; // RULE21
    irq_set[qptr_pkg::IS_PAUSE_ZERO] = misc_ev.pause_zero; // RULE22
    irq_status_next = irq_read ? irq_set : (irq_status_reg | irq_set); // RULE11 RULE24
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Register read views, zero in every reserved bit
  // ---------------------------------------------------------------------------
  logic [31:0] rx_status_word;
  logic [31:0] irq_status_word;
  logic [31:0] tx_status_word;

  always_comb begin
    rx_status_word = qptr_pkg::ZERO_WORD;
    irq_status_word = qptr_pkg::ZERO_WORD;
    tx_status_word = qptr_pkg::ZERO_WORD;
    // Next values, so an event landing in the setup cycle is not lost to the read
    rx_status_word[qptr_pkg::RS_WIDTH-1:0] = rx_status_next;
    irq_status_word[qptr_pkg::IS_WIDTH-1:0] = irq_status_next;
    tx_status_word[qptr_pkg::TS_TRANSMIT_ACTIVE] = transmit_active_flag; // RULE23
  end

  // ---------------------------------------------------------------------------
  // Read data, registered during the setup cycle
  // ---------------------------------------------------------------------------
  // Capturing at setup keeps the returned word apart from the clear in the access cycle
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  always_comb begin
    prdata_next = prdata_reg;
    if (psel && !penable && !pwrite) begin
      prdata_next = qptr_pkg::ZERO_WORD;
      case (1'b1)
        sel_rx_ptr: begin
          prdata_next = rx_current; // RULE1
        end
        sel_tx_ptr: begin
          prdata_next = tx_frame_start_next; // RULE5
        end
        sel_rx_status: begin
          prdata_next = rx_status_word; // RULE6
        end
        sel_irq_status: begin
          prdata_next = irq_status_word; // RULE11
        end
        sel_tx_status: begin
          prdata_next = tx_status_word;
        end
        default: begin
          prdata_next = qptr_pkg::ZERO_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_reg <= qptr_pkg::ZERO_WORD;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

endmodule : mac_queue_status

`default_nettype wire

// ### verilog/qptr_pkg.sv
// Purpose: Shared constants and types for the queue pointer and status block
// Assumes: APB slave, 32-bit data, one clock
// Notes: Offsets are word-aligned byte addresses
`default_nettype none

package qptr_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RX_QUEUE_POINTER_OFS = 8'h18;
  localparam logic [7:0] TX_QUEUE_POINTER_OFS = 8'h1C;
  localparam logic [7:0] RECEIVE_STATUS_OFS = 8'h20;
  localparam logic [7:0] INTERRUPT_STATUS_OFS = 8'h24;
  localparam logic [7:0] TRANSMIT_STATUS_OFS = 8'h14;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int RS_NO_BUFFER = 0;
  localparam int RS_FRAME_RECEIVED = 1;
  localparam int RS_OVERRUN = 2;
  localparam int RS_WIDTH = 3;
  localparam int TS_TRANSMIT_ACTIVE = 3;

  localparam int IS_MGMT_DONE = 0;
  localparam int IS_RX_COMPLETE = 1;
  localparam int IS_RX_USED = 2;
  localparam int IS_TX_USED = 3;
  localparam int IS_TX_UNDERRUN = 4;
  localparam int IS_RETRY_LIMIT = 5;
  localparam int IS_TX_EXHAUSTED = 6;
  localparam int IS_TX_COMPLETE = 7;
  localparam int IS_RX_OVERRUN = 10;
  localparam int IS_BUS_ERROR = 11;
  localparam int IS_PAUSE_RECEIVED = 12;
  localparam int IS_PAUSE_ZERO = 13;
  localparam int IS_WIDTH = 14;

  // ---------------------------------------------------------------------------
  // Pointer layout: word address in [31:2], descriptor index in the low bits
  // ---------------------------------------------------------------------------
  localparam int PTR_LSB = 2;
  localparam int DESC_STRIDE_LOG2 = 3;
  localparam int DESC_INDEX_BITS = 10;
  localparam logic [31:0] PTR_RESET = 32'h0000_0000;
  localparam logic [31:0] PTR_MASK = 32'hFFFF_FFFC;
  localparam logic [9:0] DESC_LAST = 10'h3FF;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Event carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic frame_stored;
    logic buffer_used;
    logic buffer_wrap;
    logic desc_owned_by_cpu;
    logic overrun;
    logic frame_start;
  } rx_events_t;

  typedef struct packed {
    logic buffer_used;
    logic buffer_wrap;
    logic frame_done;
    logic used_bit_read;
    logic underrun;
    logic retry_limit;
    logic exhausted;
    logic active;
  } tx_events_t;

  typedef struct packed {
    logic mgmt_done;
    logic pause_received;
    logic pause_zero;
    logic bus_error;
  } misc_events_t;

endpackage : qptr_pkg

`default_nettype wire

// ### verilog/queue_pointer.sv
// Purpose: One descriptor queue pointer with base, advance and wrap
// Assumes: Advance and wrap are one-cycle pulses from the DMA
// Notes: Low ten index bits count buffers, base bits stay as written
`default_nettype none

module queue_pointer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Software load
  input wire logic load,
  input wire logic [31:0] load_value,
  // DMA progress
  input wire logic advance,
  input wire logic wrap,
  // State
  output logic [31:0] base,
  output logic [31:0] current
);

  logic [31:0] base_reg;
  logic [31:0] base_next;
  logic [9:0] index_reg;
  logic [9:0] index_next;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    base_next = base_reg;
    index_next = index_reg;
    if (load) begin
      base_next = load_value & qptr_pkg::PTR_MASK;
      index_next = '0;
    end else if (advance) begin
      // Back to the written start on wrap or after the last slot
      if (wrap || index_reg == qptr_pkg::DESC_LAST) begin
        index_next = '0;
      end else begin
        index_next = index_reg + 10'h001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      base_reg <= qptr_pkg::PTR_RESET;
      index_reg <= '0;
    end else begin
      base_reg <= base_next;
      index_reg <= index_next;
    end
  end

  assign base = base_reg;
  assign current = base_reg + {19'h0_0000, index_reg, 3'h0};

endmodule : queue_pointer

`default_nettype wire
